// ==== logic/strap_pkg.sv ====
// package: constants, types and register map of the host link strap decoder
// assumes: one 10 MHz system clock, switch inputs already debounced and static
package strap_pkg;

  // ==========================================================================
  // widths
  localparam int SW_W      = 8;
  localparam int ROT_W     = 4;
  localparam int ISA_AW    = 20;
  localparam int WIN_OFS_W = 14;
  localparam int REG_AW    = 8;
  localparam int REG_DW    = 32;
  localparam int DIV_W     = 16;

  // ==========================================================================
  // baud codes and rates
  localparam logic [2:0] BAUD_2400    = 3'h0;
  localparam logic [2:0] BAUD_4800    = 3'h1;
  localparam logic [2:0] BAUD_9600    = 3'h2;
  localparam logic [2:0] BAUD_19200   = 3'h3;
  localparam logic [2:0] BAUD_38400   = 3'h4;
  localparam logic [2:0] BAUD_DEFAULT = BAUD_9600;
  localparam int RATE_2400  = 2400;
  localparam int RATE_4800  = 4800;
  localparam int RATE_9600  = 9600;
  localparam int RATE_19200 = 19200;
  localparam int RATE_38400 = 38400;
  localparam int CLK_HZ_DEFAULT = 10_000_000;

  // ==========================================================================
  // switch positions, switch Sn sits at bit n-1
  localparam int SER_BAUD_LSB = 0;
  localparam int SER_STOP     = 3;
  localparam int SER_DATA     = 4;
  localparam int SER_PAR_EN   = 5;
  localparam int SER_PAR_ODD  = 6;
  localparam int SER_FLOW     = 7;
  localparam int LNK_WARM     = 3;
  localparam int LNK_S7       = 6;
  localparam int LNK_S8       = 7;
  localparam logic [SW_W-1:0]  SERIAL_SW_DEFAULT = 8'h92;
  localparam logic [SW_W-1:0]  LINK_SW_DEFAULT   = 8'h00;
  localparam logic [ROT_W-1:0] ROT_DEFAULT       = 4'h4;

  // ==========================================================================
  // memory window
  localparam logic [ISA_AW-1:0] WIN_ORIGIN   = 20'hC0000;
  localparam logic [ROT_W-1:0]  ROT_LAST_OK  = 4'hB;

  // ==========================================================================
  // link selection, gray steps along none-console-network-card
  typedef enum logic [1:0] {
    LINK_NONE    = 2'b00,
    LINK_CONSOLE = 2'b01,
    LINK_NETWORK = 2'b11,
    LINK_PCCARD  = 2'b10
  } link_e;

  typedef struct packed {
    logic [2:0] baud;
    logic       stop_two;
    logic       data_eight;
    logic       parity_en;
    logic       parity_odd;
    logic       flow_xon;
  } serial_cfg_s;

  typedef struct packed {
    link_e link;
    logic  warm_start;
    logic  serial_en;
    logic  parallel_en;
  } link_cfg_s;

  typedef struct packed {
    logic [SW_W-1:0]  serial_sw;
    logic [SW_W-1:0]  link_sw;
    logic [ROT_W-1:0] rotary;
  } straps_s;

  typedef struct packed {
    logic [ISA_AW-1:0] addr;
    logic              memr_n;
    logic              memw_n;
  } isa_req_s;

  localparam int STRAP_W = $bits(straps_s);
  localparam straps_s STRAP_DEFAULT = '{serial_sw: SERIAL_SW_DEFAULT,
                                        link_sw:   LINK_SW_DEFAULT,
                                        rotary:    ROT_DEFAULT};
  localparam serial_cfg_s SER_CFG_DEFAULT = '{baud: BAUD_DEFAULT, stop_two: 1'b0,
                                              data_eight: 1'b1, parity_en: 1'b0,
                                              parity_odd: 1'b0, flow_xon: 1'b1};
  localparam link_cfg_s LNK_CFG_RESET = '{link: LINK_NONE, warm_start: 1'b0,
                                          serial_en: 1'b0, parallel_en: 1'b0};

  // ==========================================================================
  // register map
  localparam logic [REG_AW-1:0] REG_CTRL   = 8'h00;
  localparam logic [REG_AW-1:0] REG_SERIAL = 8'h04;
  localparam logic [REG_AW-1:0] REG_LINK   = 8'h08;
  localparam logic [REG_AW-1:0] REG_WINDOW = 8'h0C;
  localparam logic [REG_AW-1:0] REG_STRAPS = 8'h10;
  localparam int CTRL_W       = 2;
  localparam int CTRL_CARD_EN = 0;
  localparam int CTRL_TICK_EN = 1;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h3;
  localparam int WINDOW_VALID_BIT = 31;
  localparam int STATUS_VALID_BIT = 31;

endpackage

// ==== logic/strap_capture.sv ====
// strap_capture: holds a group of switch levels taken once after reset release
// assumes: switch levels are stable in the first cycle after RSTN rises
`timescale 1ns/1ns

module strap_capture #(
  parameter int              W       = 8,
  parameter logic [W-1:0]    DEFAULT = '0
) (
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire logic [W-1:0]  raw,
  output logic [W-1:0]       held,
  output logic               done
);

  typedef struct packed {
    logic         done;
    logic [W-1:0] val;
  } cap_s;

  cap_s st_ff;
  cap_s nxt_st;

  // ==========================================================================
  // capture
  // reset loads a constant; the level is caught by the clock after release
  always_comb begin
    nxt_st = st_ff;
    if (!st_ff.done) begin
      nxt_st.val  = raw;
      nxt_st.done = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_ff <= '{done: 1'b0, val: DEFAULT};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign held = st_ff.val;
  assign done = st_ff.done;

endmodule // strap_capture

// ==== logic/win_decode.sv ====
// win_decode: combinational 16 KB memory window decode on the card's host bus
// assumes: host address and command strobes are synchronous to the system clock
`timescale 1ns/1ns

module win_decode (
  input  wire logic [strap_pkg::ROT_W-1:0]     rotary,
  input  wire strap_pkg::isa_req_s             req,
  input  wire logic                            enable,
  output logic                                 valid,
  output logic [strap_pkg::ISA_AW-1:0]         base,
  output logic                                 hit,
  output logic [strap_pkg::WIN_OFS_W-1:0]      offset
);
  import strap_pkg::*;

  localparam int TAG_W = ISA_AW - WIN_OFS_W;

  logic cycle;

  // ==========================================================================
  // window place
  always_comb begin
    valid  = (rotary <= ROT_LAST_OK);
    base   = WIN_ORIGIN + ISA_AW'({rotary, {WIN_OFS_W{1'b0}}});
    cycle  = !req.memr_n || !req.memw_n;
    // only the upper address bits compare, so one aligned window decodes
    hit    = valid && enable && cycle
             && (req.addr[ISA_AW-1:WIN_OFS_W] == base[ISA_AW-1:WIN_OFS_W]);
    offset = req.addr[WIN_OFS_W-1:0];
  end

endmodule // win_decode

// ==== logic/host_link_strap_decoder.sv ====
// host_link_strap_decoder: power-up switch decode for the station host link
// and the host card's memory window, with a small register port for software
// assumes: switches static while powered, host bus strobes sampled on CLK_SYS
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns

module host_link_strap_decoder #(
  parameter int CLK_HZ = strap_pkg::CLK_HZ_DEFAULT
) (
  input  wire logic                             CLK_SYS,
  input  wire logic                             RSTN,
  input  wire logic [strap_pkg::SW_W-1:0]       SERIAL_SW,
  input  wire logic [strap_pkg::SW_W-1:0]       LINK_SW,
  input  wire logic [strap_pkg::ROT_W-1:0]      ROTARY,
  input  wire strap_pkg::isa_req_s              ISA_REQ,
  input  wire logic [strap_pkg::REG_AW-1:0]     REG_ADDR,
  input  wire logic [strap_pkg::REG_DW-1:0]     REG_WDATA,
  input  wire logic                             REG_WR,
  input  wire logic                             REG_RD,
  output logic [strap_pkg::REG_DW-1:0]          REG_RDATA,
  output strap_pkg::serial_cfg_s                SERIAL_CFG,
  output strap_pkg::link_cfg_s                  LINK_CFG,
  output logic                                  CONFIG_VALID,
  output logic                                  BAUD_TICK,
  output logic                                  WIN_HIT,
  output logic                                  WIN_WRITE,
  output logic [strap_pkg::WIN_OFS_W-1:0]       WIN_OFFSET
);
  import strap_pkg::*;

  // ==========================================================================
  // elaboration checks
  // the slowest divisor must fit the counter and the fastest must be two or more
  generate
    if ((CLK_HZ / RATE_2400) >= (1 << DIV_W)) begin : g_div_too_big
      $error("clock too fast for the baud divider width");
    end
    if ((CLK_HZ / RATE_38400) < 2) begin : g_div_too_small
      $error("clock too slow for the fastest baud rate");
    end
    // the register words must hold every field below their valid bits
    if (ISA_AW > WINDOW_VALID_BIT) begin : g_win_word
      $error("window base overlaps the window valid bit");
    end
    if ($bits(serial_cfg_s) > STATUS_VALID_BIT) begin : g_ser_word
      $error("serial word overlaps the status valid bit");
    end
    if ($bits(link_cfg_s) > STATUS_VALID_BIT) begin : g_lnk_word
      $error("link word overlaps the status valid bit");
    end
    if (STRAP_W > REG_DW) begin : g_strap_word
      $error("captured straps do not fit one register word");
    end
    // every rotary step must land inside the host address space
    if (WIN_OFS_W + ROT_W > ISA_AW) begin : g_win_span
      $error("rotary steps overrun the host address width");
    end
    if (CTRL_CARD_EN >= CTRL_W || CTRL_TICK_EN >= CTRL_W) begin : g_ctrl_bits
      $error("control bits outside the control word");
    end
  endgenerate

  // ==========================================================================
  // functions
  function automatic logic [2:0] decode_baud(input logic [SW_W-1:0] sw);
    logic [2:0] code;
    code = sw[SER_BAUD_LSB +: 3];
    if (code <= BAUD_38400) begin
      decode_baud = code;
    end else begin
      decode_baud = BAUD_DEFAULT;
    end
  endfunction

  function automatic serial_cfg_s decode_serial(input logic [SW_W-1:0] sw);
    serial_cfg_s c;
    c            = SER_CFG_DEFAULT;
    c.baud       = decode_baud(sw);
    c.stop_two   = sw[SER_STOP];
    c.data_eight = sw[SER_DATA];
    c.parity_en  = sw[SER_PAR_EN];
    // sense is forced low without parity so nothing downstream can use it
    c.parity_odd = sw[SER_PAR_EN] & sw[SER_PAR_ODD];
    c.flow_xon   = sw[SER_FLOW];
    decode_serial = c;
  endfunction

  function automatic link_cfg_s decode_link(input logic [SW_W-1:0] sw);
    link_cfg_s c;
    c = LNK_CFG_RESET;
    // only S4, S7 and S8 are looked at; the other bank positions are dead
    case ({sw[LNK_S7], sw[LNK_S8]})
      2'b00: begin
        c.link = LINK_CONSOLE;
      end
      2'b01: begin
        c.link = LINK_NETWORK;
      end
      2'b11: begin
        c.link = LINK_PCCARD;
      end
      default: begin
        c.link = LINK_NONE;
      end
    endcase
    c.serial_en   = (c.link == LINK_CONSOLE);
    c.parallel_en = (c.link == LINK_CONSOLE);
    c.warm_start  = sw[LNK_WARM];
    decode_link = c;
  endfunction

  function automatic logic [DIV_W-1:0] baud_div(input logic [2:0] code);
    int rate;
    case (code)
      BAUD_2400: begin
        rate = RATE_2400;
      end
      BAUD_4800: begin
        rate = RATE_4800;
      end
      BAUD_19200: begin
        rate = RATE_19200;
      end
      BAUD_38400: begin
        rate = RATE_38400;
      end
      default: begin
        rate = RATE_9600;
      end
    endcase
    // limitation: the divisor is rounded, so each rate is off by up to half
    // a clock per bit; at the default clock that stays well under one percent
    baud_div = DIV_W'((CLK_HZ + rate / 2) / rate);
  endfunction

  // ==========================================================================
  // switch capture
  // all three banks are caught in one cycle, so old and new settings
  // can never be mixed in one decode
  straps_s straps;
  logic    straps_done;

  strap_capture #(
    .W       (STRAP_W),
    .DEFAULT (STRAP_DEFAULT)
  ) u_straps (
    .clk  (CLK_SYS),
    .rstn (RSTN),
    .raw  ({SERIAL_SW, LINK_SW, ROTARY}),
    .held (straps),
    .done (straps_done)
  );

  // ==========================================================================
  // state
  // one register holds everything, so reset and hold are one statement each
  typedef struct packed {
    logic [CTRL_W-1:0]    ctrl;
    serial_cfg_s          ser;
    link_cfg_s            lnk;
    logic                 valid;
    logic [DIV_W-1:0]     div_cnt;
    logic                 tick;
    logic                 win_hit;
    logic                 win_write;
    logic [WIN_OFS_W-1:0] win_ofs;
    logic [REG_DW-1:0]    rdata;
  } top_s;

  localparam top_s TOP_RESET = '{ctrl: CTRL_RESET, ser: SER_CFG_DEFAULT,
                                 lnk: LNK_CFG_RESET, valid: 1'b0, div_cnt: '0,
                                 tick: 1'b0, win_hit: 1'b0, win_write: 1'b0,
                                 win_ofs: '0, rdata: '0};

  top_s st_ff;
  top_s nxt_st;

  // ==========================================================================
  // window decode
  logic                 win_valid;
  logic [ISA_AW-1:0]    win_base;
  logic                 win_hit;
  logic [WIN_OFS_W-1:0] win_ofs;

  // decode waits for the captured rotary so a moving switch is never seen
  // the hit shows one cycle after the strobe; the card side must allow for
  // that register stage when it answers the host
  win_decode u_win (
    .rotary (straps.rotary),
    .req    (ISA_REQ),
    .enable (st_ff.valid && st_ff.ctrl[CTRL_CARD_EN]),
    .valid  (win_valid),
    .base   (win_base),
    .hit    (win_hit),
    .offset (win_ofs)
  );

  // ==========================================================================
  // register read mux
  // unmapped places read as zero so software can probe for the block
  logic [REG_DW-1:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    if (REG_ADDR == REG_CTRL) begin
      rd_mux[CTRL_W-1:0] = st_ff.ctrl;
    end else if (REG_ADDR == REG_SERIAL) begin
      rd_mux[$bits(serial_cfg_s)-1:0] = st_ff.ser;
      rd_mux[STATUS_VALID_BIT]        = st_ff.valid;
    end else if (REG_ADDR == REG_LINK) begin
      rd_mux[$bits(link_cfg_s)-1:0] = st_ff.lnk;
      rd_mux[STATUS_VALID_BIT]      = st_ff.valid;
    end else if (REG_ADDR == REG_WINDOW) begin
      rd_mux[ISA_AW-1:0]       = win_base;
      rd_mux[WINDOW_VALID_BIT] = win_valid;
    end else if (REG_ADDR == REG_STRAPS) begin
      rd_mux[STRAP_W-1:0] = straps;
    end
  end

  // ==========================================================================
  // write decode
  // only the control word is writable; writes elsewhere are dropped silently
  logic ctrl_wr;

  assign ctrl_wr = REG_WR && (REG_ADDR == REG_CTRL);

  // ==========================================================================
  // next state
  always_comb begin
    nxt_st = st_ff;

    // software control
    if (ctrl_wr) begin
      nxt_st.ctrl = REG_WDATA[CTRL_W-1:0];
    end
    // data stands only in the cycle after the read strobe
    nxt_st.rdata = REG_RD ? rd_mux : '0;

    // configuration follows the once-captured switches, never the live pins
    if (straps_done) begin
      nxt_st.ser   = decode_serial(straps.serial_sw);
      nxt_st.lnk   = decode_link(straps.link_sw);
      nxt_st.valid = 1'b1;
    end

    // baud enable divider; restarts whenever it is stopped
    nxt_st.tick = 1'b0;
    if (st_ff.valid && st_ff.ctrl[CTRL_TICK_EN]) begin
      if (st_ff.div_cnt >= baud_div(st_ff.ser.baud) - DIV_W'(1)) begin
        nxt_st.div_cnt = '0;
        nxt_st.tick    = 1'b1;
      end else begin
        nxt_st.div_cnt = st_ff.div_cnt + DIV_W'(1);
      end
    end else begin
      nxt_st.div_cnt = '0;
    end

    // host window; overlap with another adapter is the host's problem
    nxt_st.win_hit   = win_hit;
    nxt_st.win_write = win_hit && !ISA_REQ.memw_n;
    nxt_st.win_ofs   = win_hit ? win_ofs : '0;
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      st_ff <= TOP_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================================
  // outputs
  // every output is a register, so the far side never sees decode glitches
  assign REG_RDATA    = st_ff.rdata;
  assign SERIAL_CFG   = st_ff.ser;
  assign LINK_CFG     = st_ff.lnk;
  assign CONFIG_VALID = st_ff.valid;
  assign BAUD_TICK    = st_ff.tick;
  assign WIN_HIT      = st_ff.win_hit;
  assign WIN_WRITE    = st_ff.win_write;
  assign WIN_OFFSET   = st_ff.win_ofs;

endmodule // host_link_strap_decoder

// ==== testbench/host_link_strap_decoder_sva.sv ====
// checker: port-level properties of the host link strap decoder
// assumes: bound to the top module, one CLK_SYS domain, sync active-low RSTN
`timescale 1ns/1ns

module host_link_strap_decoder_sva #(
  parameter int CLK_HZ = strap_pkg::CLK_HZ_DEFAULT
) (
  input wire logic                          CLK_SYS,
  input wire logic                          RSTN,
  input wire strap_pkg::isa_req_s           ISA_REQ,
  input wire logic                          REG_RD,
  input wire logic [strap_pkg::REG_DW-1:0]  REG_RDATA,
  input wire strap_pkg::serial_cfg_s        SERIAL_CFG,
  input wire strap_pkg::link_cfg_s          LINK_CFG,
  input wire logic                          CONFIG_VALID,
  input wire logic                          BAUD_TICK,
  input wire logic                          WIN_HIT,
  input wire logic                          WIN_WRITE,
  input wire logic [strap_pkg::WIN_OFS_W-1:0] WIN_OFFSET
);
  import strap_pkg::*;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  // ==========================================================================
  // assertions
  a_valid_after_reset: assert property ($rose(RSTN) |-> ##2 CONFIG_VALID)
    else $error("config valid not up two cycles after reset release");
  a_cfg_frozen: assert property (CONFIG_VALID && $past(CONFIG_VALID) |->
    $stable(SERIAL_CFG) && $stable(LINK_CFG)) else $error("config moved");
  a_baud_legal: assert property (CONFIG_VALID |-> SERIAL_CFG.baud <= BAUD_38400)
    else $error("unsupported baud code decoded");
  a_parity_sense: assert property (!SERIAL_CFG.parity_en |-> !SERIAL_CFG.parity_odd)
    else $error("parity sense set without parity");
  a_console_ports: assert property (CONFIG_VALID |-> (LINK_CFG.serial_en ==
    (LINK_CFG.link == LINK_CONSOLE)) && (LINK_CFG.parallel_en == LINK_CFG.serial_en))
    else $error("console ports mismatch link");
  a_hit_strobe: assert property (WIN_HIT |->
    $past(!ISA_REQ.memr_n || !ISA_REQ.memw_n)) else $error("hit without strobe");
  a_hit_range: assert property (WIN_HIT |-> $past(ISA_REQ.addr) >= WIN_ORIGIN
    && $past(ISA_REQ.addr) <= 20'hEFFFF) else $error("hit outside window range");
  a_hit_offset: assert property (WIN_HIT |-> WIN_OFFSET == $past(ISA_REQ.addr[13:0]))
    else $error("offset does not follow address");
  a_miss_offset: assert property (!WIN_HIT |-> WIN_OFFSET == 14'h0000)
    else $error("offset nonzero on miss");
  a_write_hit: assert property (WIN_WRITE |-> WIN_HIT && $past(!ISA_REQ.memw_n))
    else $error("write flag without write hit");
  a_tick_single: assert property (BAUD_TICK |=> !BAUD_TICK)
    else $error("baud tick longer than one cycle");
  a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0000_0000)
    else $error("read data outside read cycle");
  // ==========================================================================
  // covers
  c_hit_read: cover property (WIN_HIT && !WIN_WRITE);
  c_hit_write: cover property (WIN_WRITE);
  c_tick: cover property (BAUD_TICK);
  c_card_link: cover property (CONFIG_VALID && LINK_CFG.link == LINK_PCCARD);
endmodule // host_link_strap_decoder_sva

// ==== testbench/host_isa_model.sv ====
// host_isa_model: host computer issuing ISA memory cycles to the card
// assumes: host bus synchronous to the system clock, strobes pulled up
`timescale 1ns/1ns

module host_isa_model (
  input  wire logic          clk,
  output strap_pkg::isa_req_s req
);
  import strap_pkg::*;
  // only this card answers on the modelled bus, no overlapping decoder
  initial req = '{addr: 20'h00000, memr_n: 1'b1, memw_n: 1'b1};
  // ==========================================================================
  // one memory cycle, strobe held a full clock
  task automatic mem_cycle(input logic [ISA_AW-1:0] a, input logic wr);
    @(posedge clk);
    req <= '{addr: a, memr_n: wr, memw_n: !wr};
    @(posedge clk);
    // strobes float to the pull-up; address shows garbage, not the old value
    req <= '{addr: ~a, memr_n: 1'b1, memw_n: 1'b1};
  endtask
endmodule // host_isa_model

// ==== testbench/host_link_strap_decoder_test.sv ====
// testbench: strap decode, window decode and register port of the decoder
// assumes: host model drives the ISA side, shortened CLK_HZ for baud ticks
`timescale 1ns/1ns

module host_link_strap_decoder_test;
  import strap_pkg::*;
  localparam int CLK_HZ = 384000;
  logic                 CLK_SYS = 1'b0;
  logic                 RSTN = 1'b0;
  logic [SW_W-1:0]      SERIAL_SW = 8'h00;
  logic [SW_W-1:0]      LINK_SW = 8'h00;
  logic [ROT_W-1:0]     ROTARY = 4'h0;
  logic [REG_AW-1:0]    REG_ADDR = 8'h00;
  logic [REG_DW-1:0]    REG_WDATA = 32'h0;
  logic                 REG_WR = 1'b0;
  logic                 REG_RD = 1'b0;
  isa_req_s             ISA_REQ;
  logic [REG_DW-1:0]    REG_RDATA;
  serial_cfg_s          SERIAL_CFG;
  link_cfg_s            LINK_CFG;
  logic                 CONFIG_VALID, BAUD_TICK, WIN_HIT, WIN_WRITE;
  logic [WIN_OFS_W-1:0] WIN_OFFSET;
  int                   n_mismatch = 0;
  int                   checks = 0;

  always #50 CLK_SYS = ~CLK_SYS;

  host_link_strap_decoder #(.CLK_HZ(CLK_HZ)) dut (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
    .SERIAL_SW(SERIAL_SW), .LINK_SW(LINK_SW), .ROTARY(ROTARY), .ISA_REQ(ISA_REQ),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .SERIAL_CFG(SERIAL_CFG), .LINK_CFG(LINK_CFG),
    .CONFIG_VALID(CONFIG_VALID), .BAUD_TICK(BAUD_TICK), .WIN_HIT(WIN_HIT),
    .WIN_WRITE(WIN_WRITE), .WIN_OFFSET(WIN_OFFSET));
  host_isa_model u_host (.clk(CLK_SYS), .req(ISA_REQ));

  // ==========================================================================
  // helpers
  task automatic complete_run();
    $display("mismatches %0d, checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic reg_wr(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] d);
    @(posedge CLK_SYS);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLK_SYS);
    REG_WR <= 1'b0;
  endtask
  task automatic reg_chk(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] exp);
    @(posedge CLK_SYS);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLK_SYS);
    REG_RD <= 1'b0;
    #1 chk(REG_RDATA, exp);
  endtask
  task automatic do_reset(input logic [7:0] s, input logic [7:0] l, input logic [3:0] r);
    @(posedge CLK_SYS);
    SERIAL_SW <= s;
    LINK_SW <= l;
    ROTARY <= r;
    RSTN <= 1'b0;
    repeat (3) @(posedge CLK_SYS);
    RSTN <= 1'b1;
    repeat (3) @(posedge CLK_SYS);
    #1;
  endtask
  task automatic host_chk(input logic [19:0] a, input logic wr, input logic exp_hit);
    u_host.mem_cycle(a, wr);
    #1 chk({WIN_HIT, WIN_WRITE, 2'b00, WIN_OFFSET},
           {exp_hit, exp_hit & wr, 2'b00, exp_hit ? a[13:0] : 14'h0000});
  endtask
  task automatic wait_tick(output int n);
    n = 0;
    do begin
      @(posedge CLK_SYS);
      #1 n++;
    end while (BAUD_TICK !== 1'b1 && n < 100);
    if (n >= 100) begin
      n_mismatch++;
      complete_run();
    end
  endtask
  function automatic serial_cfg_s exp_ser(input logic [7:0] s);
    exp_ser = '{baud: (s[2:0] > 3'h4) ? BAUD_9600 : s[2:0], stop_two: s[3],
                data_eight: s[4], parity_en: s[5], parity_odd: s[5] & s[6], flow_xon: s[7]};
  endfunction
  function automatic link_cfg_s exp_lnk(input logic [7:0] l);
    link_e k;
    k = (l[7:6] == 2'b00) ? LINK_CONSOLE : (l[7:6] == 2'b10) ? LINK_NETWORK :
        (l[7:6] == 2'b11) ? LINK_PCCARD : LINK_NONE;
    exp_lnk = '{link: k, warm_start: l[3], serial_en: k == LINK_CONSOLE,
                parallel_en: k == LINK_CONSOLE};
  endfunction

  // ==========================================================================
  // main sequence
  initial begin
    logic [7:0]  s, l;
    logic [3:0]  r;
    logic [19:0] base;
    logic        ok;
    int          n;
    // every rotary value, all baud codes and link codes, other bits varied
    for (int i = 0; i < 16; i++) begin
      s = 8'(i * 37);
      l = 8'(i * 53);
      r = 4'(i);
      base = WIN_ORIGIN + 20'(r) * 20'h04000;
      ok = (r <= ROT_LAST_OK);
      do_reset(s, l, r);
      chk(32'(SERIAL_CFG), 32'(exp_ser(s)));
      chk({CONFIG_VALID, 26'h0, LINK_CFG}, {1'b1, 26'h0, exp_lnk(l)});
      host_chk(base + 20'h00123, 1'b0, ok);
      host_chk(base + 20'h03FFF, 1'b1, ok);
      host_chk(base + 20'h04000, 1'b0, 1'b0);
      host_chk(base - 20'h00001, 1'b0, 1'b0);
      reg_chk(REG_WINDOW, {ok, 11'h0, base});
      reg_chk(REG_SERIAL, {1'b1, 23'h0, exp_ser(s)});
      reg_chk(REG_LINK, {1'b1, 26'h0, exp_lnk(l)});
      reg_chk(REG_STRAPS, {12'h0, s, l, r});
      reg_chk(REG_CTRL, 32'h3);
    end
    // factory settings
    do_reset(SERIAL_SW_DEFAULT, LINK_SW_DEFAULT, ROT_DEFAULT);
    chk(32'(SERIAL_CFG), 32'(SER_CFG_DEFAULT));
    chk(32'(LINK_CFG.link), 32'(LINK_CONSOLE));
    host_chk(20'hD0000, 1'b0, 1'b1);
    host_chk(20'hD3FFF, 1'b0, 1'b1);
    host_chk(20'hD4000, 1'b0, 1'b0);
    // 9600 baud at the shortened clock: (384000 + 4800) / 9600 = 40
    wait_tick(n);
    wait_tick(n);
    chk(n, 40);
    // switch changes while powered are not seen
    @(posedge CLK_SYS);
    SERIAL_SW <= 8'h6D;
    LINK_SW <= 8'hC8;
    ROTARY <= 4'hF;
    repeat (5) @(posedge CLK_SYS);
    #1 chk(32'(SERIAL_CFG), 32'(SER_CFG_DEFAULT));
    chk(32'(LINK_CFG), 32'(exp_lnk(LINK_SW_DEFAULT)));
    host_chk(20'hD0100, 1'b0, 1'b1);
    // read-only and unmapped places, then card and tick disabled
    reg_wr(REG_SERIAL, 32'h0);
    reg_chk(REG_SERIAL, {1'b1, 23'h0, SER_CFG_DEFAULT});
    reg_chk(8'h14, 32'h0);
    reg_wr(REG_CTRL, 32'h0);
    reg_chk(REG_CTRL, 32'h0);
    host_chk(20'hD0000, 1'b0, 1'b0);
    n = 0;
    repeat (60) begin
      @(posedge CLK_SYS);
      #1 if (BAUD_TICK !== 1'b0) n++;
    end
    chk(n, 0);
    complete_run();
  end
endmodule // host_link_strap_decoder_test

bind host_link_strap_decoder host_link_strap_decoder_sva #(.CLK_HZ(CLK_HZ)) u_sva (
  .CLK_SYS(CLK_SYS), .RSTN(RSTN), .ISA_REQ(ISA_REQ), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .SERIAL_CFG(SERIAL_CFG), .LINK_CFG(LINK_CFG),
  .CONFIG_VALID(CONFIG_VALID), .BAUD_TICK(BAUD_TICK), .WIN_HIT(WIN_HIT),
  .WIN_WRITE(WIN_WRITE), .WIN_OFFSET(WIN_OFFSET));
